// ===== rtl/dual_serial_pkg.sv
// Constants, types and helpers shared by the dual serial host port
package dual_serial_pkg;
	localparam int NUM_CH = 2;
	localparam int TXBUF_WIDTH = 8;
	localparam int TXBUF_DEPTH = 2;

	// Register offsets within a channel
	localparam logic [2:0] REG_DATA = 3'h0;
	localparam logic [2:0] REG_IER  = 3'h1;
	localparam logic [2:0] REG_IIR  = 3'h2;
	localparam logic [2:0] REG_LCR  = 3'h3;
	localparam logic [2:0] REG_MCR  = 3'h4;
	localparam logic [2:0] REG_LSR  = 3'h5;
	localparam logic [2:0] REG_MSR  = 3'h6;
	localparam logic [2:0] REG_SCR  = 3'h7;

	// Field positions
	localparam int LCR_STOP  = 2;
	localparam int LCR_PEN   = 3;
	localparam int LCR_EVEN  = 4;
	localparam int LCR_BREAK = 6;
	localparam int LCR_DLAB  = 7;
	localparam int MCR_DTR   = 0;
	localparam int MCR_RTS   = 1;
	localparam int MCR_LOOP  = 4;
	localparam int IER_RX    = 0;
	localparam int IER_TX    = 1;
	localparam int IER_LS    = 2;
	localparam int IER_MS    = 3;

	// Reset values
	localparam logic [3:0]  IER_RST = 4'h0;
	localparam logic [7:0]  LCR_RST = 8'h00;
	localparam logic [4:0]  MCR_RST = 5'h00;
	localparam logic [7:0]  SCR_RST = 8'h00;
	localparam logic [15:0] DIV_RST = 16'h0001;

	// Interrupt identification codes
	localparam logic [7:0] IIR_NONE = 8'h01;
	localparam logic [7:0] IIR_LS   = 8'h06;
	localparam logic [7:0] IIR_RX   = 8'h04;
	localparam logic [7:0] IIR_TX   = 8'h02;
	localparam logic [7:0] IIR_MS   = 8'h00;

	// Oversampling counts, in baud ticks
	localparam logic [5:0] TICKS_BIT   = 6'h10;
	localparam logic [5:0] TICKS_HALF  = 6'h08;
	localparam logic [5:0] TICKS_STOP1 = 6'h10;
	localparam logic [5:0] TICKS_STOP15 = 6'h18;
	localparam logic [5:0] TICKS_STOP2 = 6'h20;

	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY,
		TX_STOP} tx_state_e;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY,
		RX_STOP} rx_state_e;

	// Index of the last data bit: 4 to 7
	function automatic logic [2:0] last_bit(input logic [7:0] lcr);
		last_bit = 3'(3'h4 + {1'b0, lcr[1:0]});
	endfunction

	// Parity over the active character bits
	function automatic logic parity_bit(input logic [7:0] data,
		input logic [7:0] lcr);
		logic [7:0] mask;
		mask = 8'hFF >> (2'h3 - lcr[1:0]);
		parity_bit = (^(data & mask)) ^ ~lcr[LCR_EVEN];
	endfunction

	// Stop length: 1, 1.5 (five-bit chars) or 2 bits
	function automatic logic [5:0] stop_ticks(input logic [7:0] lcr);
		if (!lcr[LCR_STOP])
			stop_ticks = TICKS_STOP1;
		else if (lcr[1:0] == 2'h0)
			stop_ticks = TICKS_STOP15;
		else
			stop_ticks = TICKS_STOP2;
	endfunction
endpackage

// ===== rtl/two_entry_buffer.sv
// Small valid/ready buffer in front of each transmitter
`timescale 1ns/1ns
module two_entry_buffer
	import dual_serial_pkg::*;
#(
	parameter int WIDTH = TXBUF_WIDTH,
	parameter int DEPTH = TXBUF_DEPTH
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

	logic [WIDTH-1:0] mem      [DEPTH];
	logic [WIDTH-1:0] next_mem [DEPTH];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    next_wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic [PW-1:0]    next_rd_ptr;
	logic [PW:0]      count;
	logic [PW:0]      next_count;
	logic             push;
	logic             pop;

	assign in_ready  = (count != FULL);
	assign out_valid = (count != '0);
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_comb begin
		next_mem    = mem;
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		if (push) begin
			next_mem[wr_ptr] = in_data;
			next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr + 1'b1);
		end
		if (pop)
			next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr + 1'b1);
		next_count = count;
		if (push && !pop)
			next_count = (PW+1)'(count + 1'b1);
		else if (pop && !push)
			next_count = (PW+1)'(count - 1'b1);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mem    <= '{default: '0};
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			mem    <= next_mem;
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
	end
endmodule

// ===== rtl/dual_async_serial_host_port.sv
// Host bus port and two serial channels of the dual serial element
// Contract
// - Select 0, 1, 2 enable serial channel 0, channel 1, parallel port.
// - Read strobe low drives addressed register onto the data bus.
// - Write strobe low loads data bus into addressed register.
// - Three-bit address picks the register inside the selected channel.
// - Bus buffer steer high while any channel is selected.
// - Data bus driven only during a read.
// - Bit zero is the character LSB and goes first on the line.
// - Reset idles both channels, clears registers except the divisor (loads one), and deasserts outputs.
// - Serial output marks when idle, in reset and in loopback; outside loopback the break bit holds it low, idle included.
// - Loopback ignores the external serial input.
// - Request-to-send low when its control bit is one; high on reset.
// - Terminal-ready low when its control bit is one; high on reset.
// - Baud divider divides the clock by a 16-bit divisor.
// - Character length five to eight bits per channel.
// - Parity generated and checked: even, odd or none.
// - One, one and a half or two stop bits sent.
// - Separate enables for transmit, receive, line and modem events.
// - Status readable anytime without disturbing transfers.
// - Modem status mirrors clear-to-send in bit 4, delta in bit 0.
`timescale 1ns/1ns
module dual_async_serial_host_port
	import dual_serial_pkg::*;
(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// Host bus
	input  wire logic              host_read_strobe_n,
	input  wire logic              host_write_strobe_n,
	input  wire logic [2:0]        register_select,
	input  wire logic              serial0_select_n,
	input  wire logic              serial1_select_n,
	input  wire logic              printer_port_select_n,
	input  wire logic [7:0]        host_data_bus_in,
	output logic      [7:0]        host_data_bus_out,
	output logic                   host_data_bus_oe,
	output logic                   bus_buffer_steer,
	output logic                   printer_port_enable,
	// Serial lines and modem signals, one bit per channel
	output logic      [NUM_CH-1:0] serial_tx_line,
	input  wire logic [NUM_CH-1:0] serial_rx_line,
	output logic      [NUM_CH-1:0] request_to_send_n,
	output logic      [NUM_CH-1:0] data_terminal_ready_n,
	input  wire logic [NUM_CH-1:0] clear_to_send_n,
	output logic      [NUM_CH-1:0] channel_irq
);
	// Host side state
	logic rd_q, next_rd_q, wr_q, next_wr_q;
	logic [7:0] next_host_data_bus_out;
	logic next_host_data_bus_oe, next_bus_buffer_steer;
	logic next_printer_port_enable;
	logic rd_start, wr_start;
	logic [NUM_CH-1:0] act;

	// Channel registers
	logic [3:0]  ier [NUM_CH], next_ier [NUM_CH];
	logic [7:0]  lcr [NUM_CH], next_lcr [NUM_CH];
	logic [4:0]  modem_control_reg [NUM_CH], next_mcr [NUM_CH];
	logic [7:0]  scr [NUM_CH], next_scr [NUM_CH];
	logic [15:0] div [NUM_CH], next_div [NUM_CH];
	logic [15:0] baud_cnt [NUM_CH], next_baud_cnt [NUM_CH];
	logic [7:0]  rbr [NUM_CH], next_rbr [NUM_CH];
	logic [NUM_CH-1:0] dr, next_dr, ovr, next_ovr, perr, next_perr;
	logic [NUM_CH-1:0] ferr, next_ferr, clear_to_send_changed, next_clear_to_send_changed, cts_q, next_cts_q;
	logic [NUM_CH-1:0] thre_pend, next_thre_pend, busy_q, next_busy_q;
	// Transmitter
	tx_state_e   tx_state [NUM_CH], next_tx_state [NUM_CH];
	logic [7:0]  tx_shift [NUM_CH], next_tx_shift [NUM_CH];
	logic [5:0]  tx_cnt [NUM_CH], next_tx_cnt [NUM_CH];
	logic [2:0]  tx_bit [NUM_CH], next_tx_bit [NUM_CH];
	logic [NUM_CH-1:0] tx_par, next_tx_par, tx_out, next_tx_out;
	// Receiver
	rx_state_e   rx_state [NUM_CH], next_rx_state [NUM_CH];
	logic [7:0]  rx_shift [NUM_CH], next_rx_shift [NUM_CH];
	logic [5:0]  rx_cnt [NUM_CH], next_rx_cnt [NUM_CH];
	logic [2:0]  rx_bit [NUM_CH], next_rx_bit [NUM_CH];
	logic [NUM_CH-1:0] rx_perr, next_rx_perr;
	// Outputs
	logic [NUM_CH-1:0] next_serial_tx_line, next_rts_n, next_dtr_n;
	logic [NUM_CH-1:0] next_channel_irq;
	logic [7:0]  rd_val [NUM_CH];
	// Transmit buffers
	logic [NUM_CH-1:0] buf_in_valid, buf_in_ready, buf_out_valid;
	logic [NUM_CH-1:0] buf_out_ready;
	logic [7:0]  buf_out_data [NUM_CH];

	assign act[0]   = ~serial0_select_n;
	assign act[1]   = ~serial1_select_n & serial0_select_n;
	assign rd_start = rd_q & ~host_read_strobe_n;
	assign wr_start = wr_q & ~host_write_strobe_n;

	for (genvar g = 0; g < NUM_CH; g++) begin : g_txbuf
		two_entry_buffer #(
			.WIDTH (TXBUF_WIDTH),
			.DEPTH (TXBUF_DEPTH)
		) u_buf (
			.clk       (clk),
			.rst_n     (rst_n),
			.in_valid  (buf_in_valid[g]),
			.in_ready  (buf_in_ready[g]),
			.in_data   (host_data_bus_in),
			.out_valid (buf_out_valid[g]),
			.out_ready (buf_out_ready[g]),
			.out_data  (buf_out_data[g])
		);
	end

	always_comb begin
		next_rd_q = host_read_strobe_n;
		next_wr_q = host_write_strobe_n;
		next_host_data_bus_oe = ~host_read_strobe_n & (|act);
		next_host_data_bus_out = host_data_bus_out;
		if (rd_start && act[0])
			next_host_data_bus_out = rd_val[0];
		else if (rd_start && act[1])
			next_host_data_bus_out = rd_val[1];
		next_bus_buffer_steer = (|act) | ~printer_port_select_n;
		next_printer_port_enable = ~printer_port_select_n & ~(|act);
	end

	always_comb begin
		logic wr, rd, dlab, tick, rx_in;
		logic [7:0] rx_align, iir;
		logic [5:0] tx_lim;
		wr = 1'b0; rd = 1'b0; dlab = 1'b0; tick = 1'b0; rx_in = 1'b1;
		rx_align = 8'h00; iir = IIR_NONE; tx_lim = TICKS_BIT;
		next_ier = ier; next_lcr = lcr; next_mcr = modem_control_reg; next_scr = scr;
		next_div = div; next_baud_cnt = baud_cnt; next_rbr = rbr;
		next_dr = dr; next_ovr = ovr; next_perr = perr; next_ferr = ferr;
		next_clear_to_send_changed = clear_to_send_changed; next_cts_q = cts_q; next_thre_pend = thre_pend;
		next_busy_q = busy_q;
		next_tx_state = tx_state; next_tx_shift = tx_shift;
		next_tx_cnt = tx_cnt; next_tx_bit = tx_bit; next_tx_par = tx_par;
		next_tx_out = tx_out;
		next_rx_state = rx_state; next_rx_shift = rx_shift;
		next_rx_cnt = rx_cnt; next_rx_bit = rx_bit; next_rx_perr = rx_perr;
		for (int ch = 0; ch < NUM_CH; ch++) begin
			wr = wr_start & act[ch];
			rd = rd_start & act[ch];
			dlab = lcr[ch][LCR_DLAB];
			tick = (baud_cnt[ch] <= 16'h0001);
			next_baud_cnt[ch] = tick ? div[ch] : 16'(baud_cnt[ch] - 16'h0001);
			buf_in_valid[ch] = wr & (register_select == REG_DATA) & ~dlab;
			if (wr) begin
				case (register_select)
					REG_DATA: if (dlab) next_div[ch][7:0] = host_data_bus_in;
					REG_IER: begin
						if (dlab)
							next_div[ch][15:8] = host_data_bus_in;
						else
							next_ier[ch] = host_data_bus_in[3:0];
					end
					REG_LCR: next_lcr[ch] = host_data_bus_in;
					REG_MCR: next_mcr[ch] = host_data_bus_in[4:0];
					REG_SCR: next_scr[ch] = host_data_bus_in;
					default: ;
				endcase
			end
			if (ier[ch][IER_LS] && (ovr[ch] || perr[ch] || ferr[ch]))
				iir = IIR_LS;
			else if (ier[ch][IER_RX] && dr[ch])
				iir = IIR_RX;
			else if (ier[ch][IER_TX] && thre_pend[ch])
				iir = IIR_TX;
			else if (ier[ch][IER_MS] && clear_to_send_changed[ch])
				iir = IIR_MS;
			else
				iir = IIR_NONE;
			next_channel_irq[ch] = (iir != IIR_NONE);
			case (register_select)
				REG_DATA: rd_val[ch] = dlab ? div[ch][7:0] : rbr[ch];
				REG_IER:  rd_val[ch] = dlab ? div[ch][15:8] : {4'h0, ier[ch]};
				REG_IIR:  rd_val[ch] = iir;
				REG_LCR:  rd_val[ch] = lcr[ch];
				REG_MCR:  rd_val[ch] = {3'h0, modem_control_reg[ch]};
				REG_LSR:  rd_val[ch] = {1'b0,
					~buf_out_valid[ch] & (tx_state[ch] == TX_IDLE),
					~buf_out_valid[ch], 1'b0, ferr[ch], perr[ch], ovr[ch], dr[ch]};
				REG_MSR:  rd_val[ch] = {3'h0, ~cts_q[ch], 3'h0, clear_to_send_changed[ch]};
				default:  rd_val[ch] = scr[ch];
			endcase
			// Read side effects; events below win over these clears
			if (rd) begin
				case (register_select)
					REG_DATA: if (!dlab) next_dr[ch] = 1'b0;
					REG_LSR: begin
						next_ovr[ch] = 1'b0;
						next_perr[ch] = 1'b0;
						next_ferr[ch] = 1'b0;
					end
					REG_MSR: next_clear_to_send_changed[ch] = 1'b0;
					REG_IIR: if (iir == IIR_TX) next_thre_pend[ch] = 1'b0;
					default: ;
				endcase
			end
			if (buf_in_valid[ch])
				next_thre_pend[ch] = 1'b0;
			next_busy_q[ch] = buf_out_valid[ch];
			if (busy_q[ch] && !buf_out_valid[ch])
				next_thre_pend[ch] = 1'b1;
			next_cts_q[ch] = clear_to_send_n[ch];
			if (cts_q[ch] != clear_to_send_n[ch])
				next_clear_to_send_changed[ch] = 1'b1;
			// Transmitter: start bit begins unaligned to the tick grid
			buf_out_ready[ch] = (tx_state[ch] == TX_IDLE);
			tx_lim = (tx_state[ch] == TX_STOP) ? stop_ticks(lcr[ch]) : TICKS_BIT;
			if (tx_state[ch] == TX_IDLE) begin
				if (buf_out_valid[ch]) begin
					next_tx_shift[ch] = buf_out_data[ch];
					next_tx_par[ch] = parity_bit(buf_out_data[ch], lcr[ch]);
					next_tx_state[ch] = TX_START;
					next_tx_cnt[ch] = 6'h00;
					next_tx_bit[ch] = 3'h0;
					next_tx_out[ch] = 1'b0;
				end
			end else if (tick) begin
				if (tx_cnt[ch] != 6'(tx_lim - 6'h01))
					next_tx_cnt[ch] = 6'(tx_cnt[ch] + 6'h01);
				else begin
					next_tx_cnt[ch] = 6'h00;
					case (tx_state[ch])
						TX_START: begin
							next_tx_state[ch] = TX_DATA;
							next_tx_out[ch] = tx_shift[ch][0];
						end
						TX_DATA: begin
							if (tx_bit[ch] == last_bit(lcr[ch])) begin
								next_tx_state[ch] = lcr[ch][LCR_PEN] ? TX_PARITY : TX_STOP;
								next_tx_out[ch] = lcr[ch][LCR_PEN] ? tx_par[ch] : 1'b1;
							end else begin
								next_tx_shift[ch] = tx_shift[ch] >> 1;
								next_tx_out[ch] = tx_shift[ch][1];
								next_tx_bit[ch] = 3'(tx_bit[ch] + 3'h1);
							end
						end
						TX_PARITY: begin
							next_tx_state[ch] = TX_STOP;
							next_tx_out[ch] = 1'b1;
						end
						default: begin
							next_tx_state[ch] = TX_IDLE;
							next_tx_out[ch] = 1'b1;
						end
					endcase
				end
			end
			rx_in = modem_control_reg[ch][MCR_LOOP] ? tx_out[ch] : serial_rx_line[ch];
			rx_align = rx_shift[ch] >> (2'h3 - lcr[ch][1:0]);
			if (tick) begin
				case (rx_state[ch])
					RX_IDLE: if (!rx_in) begin
						next_rx_state[ch] = RX_START;
						next_rx_cnt[ch] = 6'h00;
						next_rx_perr[ch] = 1'b0;
					end
					RX_START: if (rx_cnt[ch] == 6'(TICKS_HALF - 6'h01)) begin
						next_rx_cnt[ch] = 6'h00;
						next_rx_bit[ch] = 3'h0;
						next_rx_state[ch] = rx_in ? RX_IDLE : RX_DATA;
					end else
						next_rx_cnt[ch] = 6'(rx_cnt[ch] + 6'h01);
					default: if (rx_cnt[ch] != 6'(TICKS_BIT - 6'h01))
						next_rx_cnt[ch] = 6'(rx_cnt[ch] + 6'h01);
					else begin
						next_rx_cnt[ch] = 6'h00;
						if (rx_state[ch] == RX_DATA) begin
							next_rx_shift[ch] = {rx_in, rx_shift[ch][7:1]};
							if (rx_bit[ch] == last_bit(lcr[ch]))
								next_rx_state[ch] = lcr[ch][LCR_PEN] ? RX_PARITY : RX_STOP;
							else
								next_rx_bit[ch] = 3'(rx_bit[ch] + 3'h1);
						end else if (rx_state[ch] == RX_PARITY) begin
							next_rx_perr[ch] = rx_in != parity_bit(rx_align, lcr[ch]);
							next_rx_state[ch] = RX_STOP;
						end else begin
							next_rbr[ch] = rx_align;
							next_ovr[ch] = next_ovr[ch] | dr[ch];
							next_dr[ch] = 1'b1;
							next_perr[ch] = next_perr[ch] | rx_perr[ch];
							next_ferr[ch] = next_ferr[ch] | ~rx_in;
							next_rx_state[ch] = RX_IDLE;
						end
					end
				endcase
			end
			next_serial_tx_line[ch] = modem_control_reg[ch][MCR_LOOP] |
				(~lcr[ch][LCR_BREAK] & next_tx_out[ch]);
			next_rts_n[ch] = ~modem_control_reg[ch][MCR_RTS];
			next_dtr_n[ch] = ~modem_control_reg[ch][MCR_DTR];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_q <= 1'b1; wr_q <= 1'b1;
			host_data_bus_out <= 8'h00; host_data_bus_oe <= 1'b0;
			bus_buffer_steer <= 1'b0; printer_port_enable <= 1'b0;
			ier <= '{default: IER_RST}; lcr <= '{default: LCR_RST};
			modem_control_reg <= '{default: MCR_RST}; scr <= '{default: SCR_RST};
			div <= '{default: DIV_RST}; baud_cnt <= '{default: DIV_RST};
			rbr <= '{default: 8'h00};
			dr <= '0; ovr <= '0; perr <= '0; ferr <= '0; clear_to_send_changed <= '0;
			cts_q <= '1; thre_pend <= '0; busy_q <= '0;
			tx_state <= '{default: TX_IDLE}; tx_shift <= '{default: 8'h00};
			tx_cnt <= '{default: 6'h00}; tx_bit <= '{default: 3'h0};
			tx_par <= '0; tx_out <= '1;
			rx_state <= '{default: RX_IDLE}; rx_shift <= '{default: 8'h00};
			rx_cnt <= '{default: 6'h00}; rx_bit <= '{default: 3'h0};
			rx_perr <= '0;
			serial_tx_line <= '1;
			request_to_send_n <= '1; data_terminal_ready_n <= '1;
			channel_irq <= '0;
		end else begin
			rd_q <= next_rd_q; wr_q <= next_wr_q;
			host_data_bus_out <= next_host_data_bus_out;
			host_data_bus_oe <= next_host_data_bus_oe;
			bus_buffer_steer <= next_bus_buffer_steer;
			printer_port_enable <= next_printer_port_enable;
			ier <= next_ier; lcr <= next_lcr; modem_control_reg <= next_mcr; scr <= next_scr;
			div <= next_div; baud_cnt <= next_baud_cnt; rbr <= next_rbr;
			dr <= next_dr; ovr <= next_ovr; perr <= next_perr;
			ferr <= next_ferr; clear_to_send_changed <= next_clear_to_send_changed; cts_q <= next_cts_q;
			thre_pend <= next_thre_pend; busy_q <= next_busy_q;
			tx_state <= next_tx_state; tx_shift <= next_tx_shift;
			tx_cnt <= next_tx_cnt; tx_bit <= next_tx_bit;
			tx_par <= next_tx_par; tx_out <= next_tx_out;
			rx_state <= next_rx_state; rx_shift <= next_rx_shift;
			rx_cnt <= next_rx_cnt; rx_bit <= next_rx_bit;
			rx_perr <= next_rx_perr;
			serial_tx_line <= next_serial_tx_line;
			request_to_send_n <= next_rts_n;
			data_terminal_ready_n <= next_dtr_n;
			channel_irq <= next_channel_irq;
		end
	end
endmodule

// ===== test/dual_serial_checker.sv
// Port-level assertions for the dual serial host port
`timescale 1ns/1ns
module dual_serial_checker
	import dual_serial_pkg::*;
(
	// Clock and reset
	input wire logic              clk,
	input wire logic              rst_n,
	// Host bus
	input wire logic              host_read_strobe_n,
	input wire logic              host_write_strobe_n,
	input wire logic [2:0]        register_select,
	input wire logic              serial0_select_n,
	input wire logic              serial1_select_n,
	input wire logic              printer_port_select_n,
	input wire logic [7:0]        host_data_bus_in,
	input wire logic              host_data_bus_oe,
	input wire logic              bus_buffer_steer,
	input wire logic              printer_port_enable,
	// Serial and modem
	input wire logic [NUM_CH-1:0] serial_tx_line,
	input wire logic [NUM_CH-1:0] request_to_send_n,
	input wire logic [NUM_CH-1:0] data_terminal_ready_n
);
	logic wr_q;
	logic loop0;
	// Loop bit of channel 0, tracked from host writes
	always_ff @(posedge clk) begin
		wr_q <= host_write_strobe_n;
		if (!rst_n)
			loop0 <= 1'b0;
		else if (!host_write_strobe_n && wr_q && !serial0_select_n
			&& register_select == REG_MCR)
			loop0 <= host_data_bus_in[MCR_LOOP];
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_steer;
		$past(rst_n) |-> bus_buffer_steer == !($past(serial0_select_n)
			&& $past(serial1_select_n) && $past(printer_port_select_n));
	endproperty
	a_steer: assert property (p_steer)
		else $error("bus steer does not follow selects");
	property p_oe_cause;
		host_data_bus_oe |-> !$past(host_read_strobe_n)
			&& !($past(serial0_select_n) && $past(serial1_select_n));
	endproperty
	a_oe_cause: assert property (p_oe_cause)
		else $error("data bus driven outside a read");
	property p_rd_ans;
		!host_read_strobe_n && $past(host_read_strobe_n)
			&& !(serial0_select_n && serial1_select_n) |=> host_data_bus_oe;
	endproperty
	a_rd_ans: assert property (p_rd_ans)
		else $error("read not answered");
	property p_prn_refuse;
		serial0_select_n && serial1_select_n |=> !host_data_bus_oe;
	endproperty
	a_prn_refuse: assert property (p_prn_refuse)
		else $error("bus driven without serial select");
	property p_prn_en;
		$past(rst_n) |-> printer_port_enable == (!$past(printer_port_select_n)
			&& $past(serial0_select_n) && $past(serial1_select_n));
	endproperty
	a_prn_en: assert property (p_prn_en)
		else $error("printer enable wrong");
	property p_reset;
		$rose(rst_n) |-> serial_tx_line == 2'h3 && request_to_send_n == 2'h3
			&& data_terminal_ready_n == 2'h3 && !host_data_bus_oe;
	endproperty
	a_reset: assert property (p_reset)
		else $error("outputs not at reset values");
	property p_rts;
		!host_write_strobe_n && $past(host_write_strobe_n) && !serial0_select_n
			&& register_select == REG_MCR |-> ##3
			request_to_send_n[0] == !$past(host_data_bus_in[MCR_RTS], 3);
	endproperty
	a_rts: assert property (p_rts)
		else $error("request to send wrong");
	property p_dtr;
		!host_write_strobe_n && $past(host_write_strobe_n) && serial0_select_n
			&& !serial1_select_n && register_select == REG_MCR |-> ##3
			data_terminal_ready_n[1] == !$past(host_data_bus_in[MCR_DTR], 3);
	endproperty
	a_dtr: assert property (p_dtr)
		else $error("terminal ready wrong");
	property p_loop;
		loop0 && $past(loop0, 3) |-> serial_tx_line[0];
	endproperty
	a_loop: assert property (p_loop)
		else $error("serial out not marking in loop");
	c_read: cover property (host_data_bus_oe);
	c_prn: cover property (printer_port_enable);
	c_loop: cover property (loop0);
endmodule
bind dual_async_serial_host_port dual_serial_checker dual_serial_checker_inst (
	.clk, .rst_n, .host_read_strobe_n, .host_write_strobe_n,
	.register_select, .serial0_select_n, .serial1_select_n,
	.printer_port_select_n, .host_data_bus_in, .host_data_bus_oe,
	.bus_buffer_steer, .printer_port_enable, .serial_tx_line,
	.request_to_send_n, .data_terminal_ready_n);

// ===== test/modem_model.sv
// Modem model: takes 8N1 frames and sends each one back
`timescale 1ns/1ns
module modem_model (
	// Clock and pace
	input  wire logic       clk,
	input  wire logic       slow,
	// Serial lines
	input  wire logic       from_port,
	output logic            to_port,
	// Characters seen on the line
	output logic [7:0]      got,
	output logic            got_stb
);
	logic [7:0] echo_q[$];
	logic [7:0] c;
	initial begin
		to_port = 1'b1;
		got = 8'h00;
		got_stb = 1'b0;
	end
	always begin
		@(negedge from_port);
		repeat (8) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (16) @(posedge clk);
			got[i] <= from_port;
		end
		repeat (16) @(posedge clk);
		got_stb <= 1'b1;
		echo_q.push_back(got);
		@(posedge clk);
		got_stb <= 1'b0;
	end
	// Slow pace leaves a gap before each echo
	always begin
		@(posedge clk);
		if (echo_q.size() > 0) begin
			c = echo_q.pop_front();
			repeat (slow ? 40 : 0) @(posedge clk);
			to_port <= 1'b0;
			for (int i = 0; i < 9; i++) begin
				repeat (16) @(posedge clk);
				to_port <= (i < 8) ? c[i] : 1'b1;
			end
			repeat (16) @(posedge clk);
		end
	end
endmodule

// ===== test/tb.sv
// Self-checking testbench for the dual serial host port
`timescale 1ns/1ns
module tb
	import dual_serial_pkg::*;
;
	logic              clk;
	logic              rst_n;
	logic              host_read_strobe_n;
	logic              host_write_strobe_n;
	logic [2:0]        register_select;
	logic              serial0_select_n;
	logic              serial1_select_n;
	logic              printer_port_select_n;
	logic [7:0]        host_data_bus_in;
	logic [7:0]        host_data_bus_out;
	logic              host_data_bus_oe;
	logic              bus_buffer_steer;
	logic              printer_port_enable;
	logic [NUM_CH-1:0] serial_tx_line;
	logic [NUM_CH-1:0] serial_rx_line;
	logic [NUM_CH-1:0] request_to_send_n;
	logic [NUM_CH-1:0] data_terminal_ready_n;
	logic [NUM_CH-1:0] clear_to_send_n;
	logic [NUM_CH-1:0] irq;
	logic [7:0]        bus_drv;
	logic [7:0]        got0;
	logic              got_stb0;
	logic              line0;
	logic              line1;
	logic              noise;
	logic              slow;
	logic              oe_q;
	logic [7:0]        d;
	logic [7:0]        b[4];
	logic [7:0]        rd_q[$];
	logic [7:0]        line_q[$];
	int                seed;
	int                error_cnt;
	int                check_count;
	// Released bus shows the inverse of the last access value
	assign host_data_bus_in = host_data_bus_oe ? host_data_bus_out : bus_drv;
	assign serial_rx_line = {line1, line0 ^ noise};
	dual_async_serial_host_port dual_async_serial_host_port_inst (
		.clk, .rst_n, .host_read_strobe_n, .host_write_strobe_n,
		.register_select, .serial0_select_n, .serial1_select_n,
		.printer_port_select_n, .host_data_bus_in, .host_data_bus_out,
		.host_data_bus_oe, .bus_buffer_steer, .printer_port_enable,
		.serial_tx_line, .serial_rx_line, .request_to_send_n,
		.data_terminal_ready_n, .clear_to_send_n, .channel_irq(irq));
	modem_model modem_model_inst (.clk(clk), .slow(slow),
		.from_port(serial_tx_line[0]), .to_port(line0), .got(got0),
		.got_stb(got_stb0));
	modem_model modem_model_inst1 (.clk(clk), .slow(1'b0),
		.from_port(serial_tx_line[1]), .to_port(line1), .got(),
		.got_stb());
	always #25 clk = ~clk;
	task automatic check(input string nm, input logic [7:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Hold strobe through the answering edge, then idle two edges
	task automatic acc(input logic w, input int ch,
		input logic [2:0] a, input logic [7:0] v);
		@(posedge clk);
		serial0_select_n <= ch != 2'h0;
		serial1_select_n <= ch != 2'h1;
		printer_port_select_n <= ch != 2'h2;
		register_select <= a;
		bus_drv <= v;
		host_write_strobe_n <= !w;
		host_read_strobe_n <= w;
		repeat (2) @(posedge clk);
		host_write_strobe_n <= 1'b1;
		host_read_strobe_n <= 1'b1;
		{serial0_select_n, serial1_select_n, printer_port_select_n} <= 3'h7;
		bus_drv <= ~v;
		repeat (2) @(posedge clk);
	endtask
	task automatic wr(input int ch, input logic [2:0] a,
		input logic [7:0] v);
		acc(1'b1, ch, a, v);
	endtask
	task automatic rd(input int ch, input logic [2:0] a,
		input logic [7:0] e);
		rd_q.push_back(e);
		acc(1'b0, ch, a, e);
	endtask
	always @(negedge clk) begin
		if (host_data_bus_oe && !oe_q) begin
			check("read pending", 8'(rd_q.size() != 0), 8'h01);
			if (rd_q.size() != 0)
				check("read data", host_data_bus_out, rd_q.pop_front());
		end
		oe_q = host_data_bus_oe;
		if (got_stb0)
			check("line char", got0, line_q.pop_front());
	end
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		tally_and_finish;
	end
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		host_read_strobe_n = 1'b1;
		host_write_strobe_n = 1'b1;
		register_select = 3'h0;
		{serial0_select_n, serial1_select_n, printer_port_select_n} = 3'h7;
		bus_drv = 8'h00;
		clear_to_send_n = 2'h3;
		noise = 1'b0;
		slow = 1'b0;
		oe_q = 1'b0;
		seed = 32'hea36cf26;
		error_cnt = 0;
		check_count = 0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		rd(0, REG_LCR, LCR_RST);
		rd(1, REG_MCR, 8'(MCR_RST));
		rd(0, REG_IIR, IIR_NONE);
		rd(1, REG_LSR, 8'h60);
		$display("test reset done");
		for (int i = 0; i < 2; i++) begin
			d = 8'($random(seed));
			wr(2'(i), REG_SCR, d);
			wr(2'(1 - i), REG_SCR, ~d);
			rd(2'(i), REG_SCR, d);
			rd(2'(1 - i), REG_SCR, ~d);
		end
		wr(1, REG_LCR, 8'h80);
		wr(1, REG_DATA, d);
		rd(1, REG_DATA, d);
		acc(1'b0, 2'h2, REG_SCR, 8'h00);
		$display("test registers done");
		wr(0, REG_MCR, 8'h02);
		wr(1, REG_MCR, 8'h01);
		repeat (3) @(posedge clk);
		check("rts", {6'h00, request_to_send_n}, 8'h02);
		check("dtr", {6'h00, data_terminal_ready_n}, 8'h01);
		$display("test modem outputs done");
		// fill buffer; fourth write is dropped
		wr(0, REG_LCR, 8'h03);
		slow <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			b[i] = 8'($random(seed));
			if (i < 3)
				line_q.push_back(b[i]);
			wr(0, REG_DATA, b[i]);
		end
		rd(0, REG_LSR, 8'h00);
		repeat (1000) @(posedge clk);
		rd(0, REG_LSR, 8'h63);
		rd(0, REG_DATA, b[2]);
		rd(0, REG_LSR, 8'h60);
		$display("test stream done");
		wr(0, REG_MCR, 8'h10);
		wr(0, REG_IER, 8'h01);
		noise <= 1'b1;
		d = 8'($random(seed));
		wr(0, REG_DATA, d);
		repeat (400) @(posedge clk);
		check("irq", {6'h00, irq}, 8'h01);
		rd(0, REG_IIR, IIR_RX);
		rd(0, REG_LSR, 8'h61);
		rd(0, REG_DATA, d);
		noise <= 1'b0;
		wr(0, REG_MCR, 8'h00);
		$display("test loopback done");
		clear_to_send_n <= 2'h1;
		repeat (3) @(posedge clk);
		rd(1, REG_MSR, 8'h11);
		rd(1, REG_MSR, 8'h10);
		$display("test modem status done");
		repeat (300) @(posedge clk);
		check("pending", 8'(rd_q.size() + line_q.size()), 8'h00);
		tally_and_finish;
	end
endmodule
